/* verilog/bmi_pkg.sv */
package bmi_pkg;

    // Mode selector encoding
    typedef enum logic [1:0] {
        BMI_MODE_OFF  = 2'b00,
        BMI_MODE_OPER = 2'b01,
        BMI_MODE_AUTO = 2'b10
    } bmi_mode_e;

    // Drive start state machine
    typedef enum logic [1:0] {
        BMI_DRV_IDLE = 2'b00,
        BMI_DRV_WAIT = 2'b01,
        BMI_DRV_RUN  = 2'b10
    } bmi_drv_e;

    // Clock and timing
    localparam int unsigned BMI_CLK_HZ       = 50_000_000;
    localparam int unsigned BMI_START_DLY_MS = 3000;
    localparam int unsigned BMI_START_CYC    = (BMI_CLK_HZ / 1000) * BMI_START_DLY_MS;

    // Register byte offsets
    localparam logic [7:0] BMI_OFF_CTRL   = 8'h00;
    localparam logic [7:0] BMI_OFF_STATUS = 8'h04;
    localparam logic [7:0] BMI_OFF_OUTS   = 8'h08;

    // Control register fields and reset value
    localparam int unsigned BMI_CTRL_MODE_LSB = 0;
    localparam int unsigned BMI_CTRL_BELL     = 2;
    localparam logic [31:0] BMI_CTRL_RST      = 32'h0000_0000;

    // Status register fields
    localparam int unsigned BMI_ST_MODE_LSB = 0;
    localparam int unsigned BMI_ST_DRV_LSB  = 2;
    localparam int unsigned BMI_ST_ESTOP    = 4;
    localparam int unsigned BMI_ST_PCA      = 5;
    localparam int unsigned BMI_ST_GPU      = 6;
    localparam int unsigned BMI_ST_CABLE    = 7;
    localparam int unsigned BMI_ST_OBST     = 8;

    // Input vector bit positions
    localparam int unsigned BMI_NIN       = 26;
    localparam int unsigned BMI_I_FWD     = 0;
    localparam int unsigned BMI_I_REV     = 1;
    localparam int unsigned BMI_I_TRIG    = 2;
    localparam int unsigned BMI_I_RAISE   = 3;
    localparam int unsigned BMI_I_LOWER   = 4;
    localparam int unsigned BMI_I_ROTL    = 5;
    localparam int unsigned BMI_I_ROTR    = 6;
    localparam int unsigned BMI_I_ESTOP0  = 7;
    localparam int unsigned BMI_I_ESTOP1  = 8;
    localparam int unsigned BMI_I_ESTOP2  = 9;
    localparam int unsigned BMI_I_EXT_SLW = 10;
    localparam int unsigned BMI_I_EXT_LIM = 11;
    localparam int unsigned BMI_I_RET_SLW = 12;
    localparam int unsigned BMI_I_RET_LIM = 13;
    localparam int unsigned BMI_I_UP_LIM  = 14;
    localparam int unsigned BMI_I_DN_LIM  = 15;
    localparam int unsigned BMI_I_ROTL_LIM = 16;
    localparam int unsigned BMI_I_ROTR_LIM = 17;
    localparam int unsigned BMI_I_SLOPE_UP = 18;
    localparam int unsigned BMI_I_SLOPE_DN = 19;
    localparam int unsigned BMI_I_SWING_L = 20;
    localparam int unsigned BMI_I_SWING_R = 21;
    localparam int unsigned BMI_I_PCA     = 22;
    localparam int unsigned BMI_I_GPU     = 23;
    localparam int unsigned BMI_I_CABLE   = 24;
    localparam int unsigned BMI_I_CANOPY  = 25;

    localparam int unsigned BMI_JOY_W = 8;

endpackage : bmi_pkg

/* verilog/bmi_interlock.sv */
module bmi_interlock
    import bmi_pkg::*;
#(
    parameter int unsigned START_CYC = BMI_START_CYC
) (
    // Clock and reset
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    // AXI4-Lite slave
    input  wire logic [7:0]               s_axi_awaddr,
    input  wire logic                     s_axi_awvalid,
    output logic                          s_axi_awready,
    input  wire logic [31:0]              s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output logic                          s_axi_wready,
    output logic [1:0]                    s_axi_bresp,
    output logic                          s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    input  wire logic [7:0]               s_axi_araddr,
    input  wire logic                     s_axi_arvalid,
    output logic                          s_axi_arready,
    output logic [31:0]                   s_axi_rdata,
    output logic [1:0]                    s_axi_rresp,
    output logic                          s_axi_rvalid,
    input  wire logic                     s_axi_rready,
    // Field pins, asynchronous
    input  wire logic [bmi_pkg::BMI_NIN-1:0]   field_in,
    input  wire logic [bmi_pkg::BMI_JOY_W-1:0] joy_fa,
    input  wire logic [bmi_pkg::BMI_JOY_W-1:0] joy_lr,
    input  wire logic                     leveler_up,
    input  wire logic                     leveler_dn,
    // Motion outputs
    output logic                          drive_fwd,
    output logic                          drive_rev,
    output logic [bmi_pkg::BMI_JOY_W-1:0] drive_speed,
    output logic                          steer_left,
    output logic                          steer_right,
    output logic [bmi_pkg::BMI_JOY_W-1:0] steer_speed,
    output logic                          lift_raise,
    output logic                          lift_lower,
    output logic                          rot_left,
    output logic                          rot_right,
    output logic                          wheel_brake,
    output logic                          lift_stop,
    output logic                          leveler_retract,
    output logic                          leveler_enable,
    // Warning devices and indicators
    output logic                          alarm_bell,
    output logic                          travel_bell,
    output logic                          beacon,
    output logic                          ind_amber,
    output logic                          ind_green,
    output logic                          warn_pca,
    output logic                          warn_gpu,
    output logic                          warn_cable,
    output logic                          warn_obst,
    output logic                          buzzer
);
    import bmi_pkg::*;

    localparam int unsigned CW = $clog2(START_CYC + 1);
    localparam logic [BMI_JOY_W-1:0] JOY_MID = 8'h80;

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    logic [BMI_NIN-1:0]   sy1_r, in_r;
    logic [BMI_JOY_W-1:0] fa1_r, fa_r, lr1_r, lr_r;
    logic [1:0]           lv1_r, lv_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sy1_r <= '0;
            in_r  <= '0;
            fa1_r <= JOY_MID;
            fa_r  <= JOY_MID;
            lr1_r <= JOY_MID;
            lr_r  <= JOY_MID;
            lv1_r <= 2'h0;
            lv_r  <= 2'h0;
        end else begin
            sy1_r <= field_in;
            in_r  <= sy1_r;
            fa1_r <= joy_fa;
            fa_r  <= fa1_r;
            lr1_r <= joy_lr;
            lr_r  <= lr1_r;
            lv1_r <= {leveler_up, leveler_dn};
            lv_r  <= lv1_r;
        end
    end

    // ************************************************************
    // Register file
    // ************************************************************
    logic [31:0] ctrl_r;
    logic        aw_ok, w_ok, rd_go;
    bmi_mode_e   mode;
    bmi_drv_e    drv_r;
    logic [31:0] status, outs;

    assign mode  = bmi_mode_e'(ctrl_r[BMI_CTRL_MODE_LSB +: 2]);
    assign aw_ok = s_axi_awvalid && s_axi_awready;
    assign w_ok  = s_axi_wvalid && s_axi_wready;
    assign rd_go = s_axi_arvalid && s_axi_arready;

    // Address and data latched independently, response after both
    logic        aw_got_r, w_got_r;
    logic [7:0]  awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r      <= 1'b0;
            w_got_r       <= 1'b0;
            awaddr_r      <= 8'h00;
            wdata_r       <= 32'h0000_0000;
            wstrb_r       <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
            ctrl_r        <= BMI_CTRL_RST;
        end else begin
            s_axi_awready <= !aw_got_r && !aw_ok && !s_axi_bvalid;
            s_axi_wready  <= !w_got_r && !w_ok && !s_axi_bvalid;
            if (aw_ok) begin
                aw_got_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (w_ok) begin
                w_got_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (aw_got_r && w_got_r && !s_axi_bvalid) begin
                aw_got_r     <= 1'b0;
                w_got_r      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (awaddr_r[7:2] == BMI_OFF_CTRL[7:2]) begin
                    s_axi_bresp <= 2'h0;
                    if (wstrb_r[0]) begin
                        ctrl_r[7:0] <= wdata_r[7:0];
                    end
                end else begin
                    s_axi_bresp <= 2'h2;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'h0;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !rd_go;
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= 2'h0;
                case (s_axi_araddr[7:2])
                    BMI_OFF_CTRL[7:2]:   s_axi_rdata <= ctrl_r;
                    BMI_OFF_STATUS[7:2]: s_axi_rdata <= status;
                    BMI_OFF_OUTS[7:2]:   s_axi_rdata <= outs;
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= 2'h2;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Interlock conditions
    // ************************************************************
    logic estop, manual_ok, horiz_inh, start_ok;
    logic fwd_ok, rev_ok, up_ok, dn_ok, rl_ok, rr_ok, half;

    assign estop     = in_r[BMI_I_ESTOP0] | in_r[BMI_I_ESTOP1] | in_r[BMI_I_ESTOP2];
    // Off and auto-level both lock manual controls out
    assign manual_ok = (mode == BMI_MODE_OPER) && !estop;
    assign horiz_inh = in_r[BMI_I_PCA] | in_r[BMI_I_GPU] | !in_r[BMI_I_CABLE];
    assign start_ok  = manual_ok && in_r[BMI_I_TRIG] && !horiz_inh;

    // Proximity stop shares the extend limit input; reverse is never gated by it
    assign fwd_ok = !in_r[BMI_I_EXT_LIM] && !in_r[BMI_I_CANOPY]
                  && !in_r[BMI_I_SLOPE_UP] && !in_r[BMI_I_SLOPE_DN];
    assign rev_ok = !in_r[BMI_I_RET_LIM];
    assign up_ok  = !in_r[BMI_I_UP_LIM] && !in_r[BMI_I_SLOPE_UP];
    assign dn_ok  = !in_r[BMI_I_DN_LIM] && !in_r[BMI_I_SLOPE_DN];
    assign rl_ok  = !in_r[BMI_I_ROTL_LIM] && !in_r[BMI_I_SWING_L] && !in_r[BMI_I_CANOPY];
    assign rr_ok  = !in_r[BMI_I_ROTR_LIM] && !in_r[BMI_I_SWING_R] && !in_r[BMI_I_CANOPY];
    // Extend or retract slow zone gives half speed
    assign half   = in_r[BMI_I_EXT_SLW] | in_r[BMI_I_RET_SLW];

    // ************************************************************
    // Drive start delay
    // ************************************************************
    logic [CW-1:0] cnt_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            drv_r <= BMI_DRV_IDLE;
            cnt_r <= '0;
        end else if (!start_ok) begin
            drv_r <= BMI_DRV_IDLE;
            cnt_r <= '0;
        end else begin
            case (drv_r)
                BMI_DRV_IDLE: begin
                    drv_r <= BMI_DRV_WAIT;
                    cnt_r <= CW'(1);
                end
                BMI_DRV_WAIT: begin
                    if (cnt_r >= CW'(START_CYC)) begin
                        drv_r <= BMI_DRV_RUN;
                    end else begin
                        cnt_r <= cnt_r + CW'(1);
                    end
                end
                BMI_DRV_RUN: drv_r <= BMI_DRV_RUN;
                default:     drv_r <= BMI_DRV_IDLE;
            endcase
        end
    end

    // ************************************************************
    // Output stage
    // ************************************************************
    logic run, fa_fwd, fa_rev, lr_l, lr_r_dir;
    logic [BMI_JOY_W-1:0] fa_mag, lr_mag, spd, fa_dif, lr_dif;
    logic f_n, r_n, u_n, d_n, sl_n, sr_n, ol_n, or_n;

    assign run      = (drv_r == BMI_DRV_RUN) && start_ok;
    assign fa_fwd   = fa_r > JOY_MID;
    assign fa_rev   = fa_r < JOY_MID;
    assign lr_l     = lr_r < JOY_MID;
    assign lr_r_dir = lr_r > JOY_MID;
    assign fa_dif   = fa_fwd ? fa_r - JOY_MID : JOY_MID - fa_r;
    assign lr_dif   = lr_r_dir ? lr_r - JOY_MID : JOY_MID - lr_r;
    // Deflection doubled; full reverse or left saturates instead of wrapping to zero
    assign fa_mag   = fa_dif[7] ? 8'hFF : {fa_dif[6:0], 1'b0};
    assign lr_mag   = lr_dif[7] ? 8'hFF : {lr_dif[6:0], 1'b0};
    assign spd      = half ? (fa_mag >> 1) : fa_mag;

    // Opposing commands cancel rather than pick a winner
    assign f_n  = run && fa_fwd && fwd_ok;
    assign r_n  = run && fa_rev && rev_ok;
    assign sl_n = run && lr_l && !in_r[BMI_I_SWING_L];
    assign sr_n = run && lr_r_dir && !in_r[BMI_I_SWING_R];
    assign u_n  = ((manual_ok && in_r[BMI_I_RAISE] && !in_r[BMI_I_LOWER])
                || (mode == BMI_MODE_AUTO && !estop && lv_r == 2'b10)) && up_ok;
    assign d_n  = ((manual_ok && in_r[BMI_I_LOWER] && !in_r[BMI_I_RAISE])
                || (mode == BMI_MODE_AUTO && !estop && lv_r == 2'b01)) && dn_ok;
    assign ol_n = manual_ok && in_r[BMI_I_ROTL] && !in_r[BMI_I_ROTR] && rl_ok;
    assign or_n = manual_ok && in_r[BMI_I_ROTR] && !in_r[BMI_I_ROTL] && rr_ok;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            drive_fwd   <= 1'b0;
            drive_rev   <= 1'b0;
            drive_speed <= '0;
            steer_left  <= 1'b0;
            steer_right <= 1'b0;
            steer_speed <= '0;
            lift_raise  <= 1'b0;
            lift_lower  <= 1'b0;
            rot_left    <= 1'b0;
            rot_right   <= 1'b0;
            wheel_brake <= 1'b1;
            lift_stop   <= 1'b1;
        end else begin
            drive_fwd   <= f_n;
            drive_rev   <= r_n;
            drive_speed <= (f_n || r_n) ? spd : '0;
            steer_left  <= sl_n;
            steer_right <= sr_n;
            steer_speed <= (sl_n || sr_n) ? lr_mag : '0;
            lift_raise  <= u_n;
            lift_lower  <= d_n;
            rot_left    <= ol_n;
            rot_right   <= or_n;
            wheel_brake <= !(f_n || r_n || sl_n || sr_n);
            lift_stop   <= !(u_n || d_n);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            leveler_retract <= 1'b1;
            leveler_enable  <= 1'b0;
            alarm_bell      <= 1'b0;
            travel_bell     <= 1'b0;
            beacon          <= 1'b0;
            ind_amber       <= 1'b0;
            ind_green       <= 1'b0;
            warn_pca        <= 1'b0;
            warn_gpu        <= 1'b0;
            warn_cable      <= 1'b0;
            warn_obst       <= 1'b0;
            buzzer          <= 1'b0;
        end else begin
            leveler_retract <= (mode != BMI_MODE_AUTO);
            leveler_enable  <= (mode == BMI_MODE_AUTO) && !estop;
            alarm_bell      <= run;
            travel_bell     <= (drv_r == BMI_DRV_WAIT) || f_n || r_n || sl_n || sr_n
                             || ctrl_r[BMI_CTRL_BELL];
            beacon          <= (mode == BMI_MODE_OPER);
            ind_amber       <= (drv_r == BMI_DRV_WAIT) && start_ok;
            ind_green       <= run;
            warn_pca        <= in_r[BMI_I_PCA];
            warn_gpu        <= in_r[BMI_I_GPU];
            warn_cable      <= !in_r[BMI_I_CABLE];
            warn_obst       <= in_r[BMI_I_SWING_L] | in_r[BMI_I_SWING_R];
            buzzer          <= in_r[BMI_I_SWING_L] | in_r[BMI_I_SWING_R];
        end
    end

    assign status = {23'h0, warn_obst, warn_cable, warn_gpu, warn_pca, estop,
                     drv_r, ctrl_r[1:0]};
    assign outs   = {18'h0, lift_stop, wheel_brake, travel_bell, alarm_bell, beacon,
                     rot_right, rot_left, lift_lower, lift_raise, steer_right,
                     steer_left, drive_rev, drive_fwd, ind_green};

    // ************************************************************
    // Assertions
    // ************************************************************
    a_off_no_motion: assert property (@(posedge aclk) disable iff (!aresetn)
        (mode == BMI_MODE_OFF) |=> !(drive_fwd || drive_rev || lift_raise || lift_lower
                                     || rot_left || rot_right))
        else $error("motion in off mode");
    a_brake_idle: assert property (@(posedge aclk) disable iff (!aresetn)
        !(drive_fwd || drive_rev || steer_left || steer_right) |-> wheel_brake)
        else $error("brake released while idle");
    a_lift_stop_idle: assert property (@(posedge aclk) disable iff (!aresetn)
        !(lift_raise || lift_lower) |-> lift_stop)
        else $error("lift stop open while idle");
    a_no_opposed: assert property (@(posedge aclk) disable iff (!aresetn)
        !(drive_fwd && drive_rev) && !(lift_raise && lift_lower) && !(rot_left && rot_right))
        else $error("opposing outputs");
    a_estop_halt: assert property (@(posedge aclk) disable iff (!aresetn)
        estop |=> !(drive_fwd || drive_rev || lift_raise || lift_lower || rot_left || rot_right))
        else $error("motion during emergency stop");
    a_ext_lim_fwd: assert property (@(posedge aclk) disable iff (!aresetn)
        in_r[BMI_I_EXT_LIM] |=> !drive_fwd)
        else $error("forward past extend limit");
    a_canopy_block: assert property (@(posedge aclk) disable iff (!aresetn)
        in_r[BMI_I_CANOPY] |=> !(drive_fwd || rot_left || rot_right))
        else $error("canopy down motion");
    a_beacon_mode: assert property (@(posedge aclk) disable iff (!aresetn)
        (mode == BMI_MODE_OPER) |=> beacon)
        else $error("beacon off in operate");
    a_start_delay: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(ind_green) |-> $past(ind_amber, 2))
        else $error("green without amber wait");
    a_horiz_inhibit: assert property (@(posedge aclk) disable iff (!aresetn)
        horiz_inh |=> !(drive_fwd || drive_rev) ##0 (warn_pca || warn_gpu || warn_cable))
        else $error("horizontal motion under inhibit");

    c_drive_run: cover property (@(posedge aclk) disable iff (!aresetn) $rose(ind_green));
    c_auto_lower: cover property (@(posedge aclk) disable iff (!aresetn)
        (mode == BMI_MODE_AUTO) && lift_lower);
    c_half_speed: cover property (@(posedge aclk) disable iff (!aresetn) drive_fwd && half);

endmodule // bmi_interlock

/* bench/bmi_field_model.sv */
module bmi_field_model
    import bmi_pkg::*;
(
    // Clock
    input  wire logic                      aclk,
    // Operator and switch wishes from the bench
    input  wire logic [bmi_pkg::BMI_NIN-1:0] want,
    // Switch contacts
    output logic      [bmi_pkg::BMI_NIN-1:0] field_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // Contacts stay made only while the operator keeps the control held
    always_ff @(posedge aclk) begin
        field_in <= want;
    end
endmodule // bmi_field_model

/* bench/tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    // ****
    // Stimulus
    // ****
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, drive_fwd, drive_rev, lift_raise, lift_lower, rot_left;
    logic rot_right, wheel_brake, lift_stop, leveler_retract, leveler_enable, alarm_bell;
    logic travel_bell, beacon, ind_amber, ind_green, warn_pca, steer_left, steer_right, warn_obst;
    logic buzzer, lv_dn = 0;
    logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, joy_fa = 8'h80, drive_speed;
    logic [7:0]  joy_lr = 8'h80, steer_speed;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd_d;
    logic [3:0]  s_axi_wstrb = 0;
    logic [1:0]  s_axi_rresp, rr, s_axi_bresp, br;
    logic [25:0] want = 0, field_in;
    int          n_fail = 0, cmp_count = 0, k = 0;
    // Mode, switches, then {raise, lower, rotL, rotR, lift stop, beacon}
    logic [33:0] rows [8] = '{{2'h0, 26'h0000008, 6'h02}, {2'h1, 26'h0000008, 6'h21},
        {2'h1, 26'h0000018, 6'h03}, {2'h1, 26'h0004008, 6'h03}, {2'h1, 26'h2000020, 6'h03},
        {2'h1, 26'h0000040, 6'h07}, {2'h2, 26'h0000008, 6'h10}, {2'h1, 26'h0000088, 6'h03}};
    bmi_interlock #(.START_CYC(20)) u_bmi_interlock (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .field_in, .joy_fa, .joy_lr, .leveler_up(1'b0),
        .leveler_dn(lv_dn), .drive_fwd, .drive_rev, .drive_speed, .steer_left,
        .steer_right, .steer_speed, .lift_raise, .lift_lower, .rot_left, .rot_right,
        .wheel_brake, .lift_stop, .leveler_retract, .leveler_enable, .alarm_bell,
        .travel_bell, .beacon, .ind_amber, .ind_green, .warn_pca, .warn_gpu(),
        .warn_cable(), .warn_obst, .buzzer);
    bmi_field_model u_bmi_field_model (.aclk, .want, .field_in);
    initial begin
        forever #10 aclk = ~aclk;
    end
    task end_of_test;
        if (n_fail == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task fail_out;
        n_fail++;
        end_of_test;
    endtask
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    task wt(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 50);
        br = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (!s_axi_bvalid) fail_out;
    endtask
    task automatic rd(input logic [7:0] a);
        int n = 0;
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 50);
        rd_d = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (!s_axi_rvalid) fail_out;
    endtask
    initial begin
        wt(10);
        aresetn <= 1'b1;
        wt(2);
        chk("rst", 32'({wheel_brake, lift_stop, leveler_retract}), 32'h7);
        for (int i = 0; i < 8; i++) begin
            wr(8'h00, 32'(rows[i][33:32]));
            lv_dn <= (rows[i][33:32] == 2'h2);
            want <= rows[i][31:6];
            wt(6);
            chk("motion", 32'({lift_raise, lift_lower, rot_left, rot_right, lift_stop,
                beacon}), 32'(rows[i][5:0]));
        end
        chk("lvl", 32'({leveler_retract, leveler_enable}), 32'h2);
        wr(8'h40, 32'h0);
        chk("bresp", 32'(br), 32'h2);
        rd(8'h40);
        chk("unmapped", {rr, rd_d[29:0]}, 32'h80000000);
        // Drive start: amber and bell during the hold-off, brake still set
        joy_fa <= 8'hC0;
        joy_lr <= 8'hA0;
        want <= 26'h1000004;
        wt(6);
        chk("wait", 32'({ind_amber, travel_bell, wheel_brake, drive_fwd}), 32'hE);
        while (ind_green !== 1'b1 && k < 100) begin
            wt(1);
            k++;
        end
        if (ind_green !== 1'b1) fail_out;
        wt(3);
        chk("run", 32'({drive_fwd, alarm_bell, wheel_brake, travel_bell}), 32'hD);
        chk("speed", 32'(drive_speed), 32'h80);
        chk("steer", 32'({steer_left, steer_right, steer_speed}), 32'h140);
        want <= 26'h1200004;
        wt(6);
        chk("swing", 32'({steer_right, warn_obst, buzzer, drive_fwd}), 32'h7);
        want <= 26'h1000404;
        wt(6);
        chk("slow", 32'(drive_speed), 32'h40);
        want <= 26'h1000C04;
        wt(6);
        chk("stop", 32'(drive_fwd), 32'h0);
        joy_fa <= 8'h00;
        wt(6);
        chk("away", 32'({drive_rev, drive_fwd, drive_speed}), 32'h27F);
        want <= 26'h1000C00;
        wt(6);
        chk("release", 32'({ind_green, wheel_brake, drive_rev}), 32'h2);
        want <= 26'h1400C04;
        wt(6);
        chk("air", 32'({drive_rev, warn_pca, ind_amber}), 32'h2);
        rd(8'h04);
        chk("status", rd_d, 32'h21);
        // Mid-run reset clears the mode and reapplies brake and lift stop
        aresetn <= 1'b0;
        wt(3);
        aresetn <= 1'b1;
        wt(2);
        chk("rst2", 32'({beacon, wheel_brake, lift_stop, leveler_retract}), 32'h7);
        end_of_test;
    end
endmodule // tb
